//--- spm_device.sv
// What this block does
// - Time each flash write 3.7 to 4.5 ms
// - 4K boot start from size fuse code
// - 4K region split at 0xC00
// - 4K page bits 12:6, word bits 5:1
// - 8K boot start from size fuse code
// - 8K region split at 0x1C00
// - 8K page bits 13:7, word bits 6:1
// - Ignore pointer bits above page index
// - Pointer bit 0 zero for stores
// - Pointer bits 5:1 zero on page write (4K word index)
// - Block region fetch during erase/write
// - Busy flag cleared only by re-enable
// - Enable bit held until operation completes
// - Wait for EEPROM write before command
// - Fill buffer one word per command
// - Re-enable region after each erase/write
// - Store within four cycles or discard
//
// Added by the designer: the placing of the registers and the strobed register port.
module spm_device #(
    parameter bit BIG_VARIANT = 1'b0,
    parameter int PROG_CYCLES = spm_pkg::PROG_CYCLES,
    parameter int WORDS       = BIG_VARIANT ? 64 : 32
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Link
    spm_link_if.device       link,
    // Geometry view and done pulse
    output logic [15:0]      boot_start,
    output logic [15:0]      boot_end,
    output logic [6:0]       page_index,
    output logic [5:0]       word_index,
    output logic             op_done
);
    localparam int TW = 24;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PROG} state_type;

    typedef struct packed {
        state_type   st;
        logic [2:0]  arm_cnt;
        logic [7:0]  ctrl;
        logic [TW-1:0] timer;
        logic        busy;
        logic        halt;
        logic        block;
        logic        done;
        logic [6:0]  target_page;
    } dev_type;

    dev_type r;
    dev_type next_r;
    logic [15:0] buffer [WORDS];
    logic [15:0] ptr;
    logic        in_no_concurrent_read_region;
    logic        buf_we;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    always_comb begin
        ptr = link.pointer;
        if (BIG_VARIANT) begin
            boot_start = spm_pkg::BOOT_START_8K[link.boot_size_sel];
            boot_end   = spm_pkg::BOOT_END_8K;
            page_index = ptr[spm_pkg::PAGE_MSB_8K:spm_pkg::PAGE_LSB_8K];
            word_index = ptr[6:1];
            in_no_concurrent_read_region    = {3'h0, page_index, 6'h00} >=
                         spm_pkg::NO_CONCURRENT_READ_REGION_START_8K;
        end else begin
            boot_start = spm_pkg::BOOT_START_4K[link.boot_size_sel];
            boot_end   = spm_pkg::BOOT_END_4K;
            page_index = ptr[spm_pkg::PAGE_MSB_4K:spm_pkg::PAGE_LSB_4K];
            word_index = {1'b0, ptr[5:1]};
            in_no_concurrent_read_region    = {4'h0, page_index, 5'h00} >=
                         spm_pkg::NO_CONCURRENT_READ_REGION_START_4K;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        buf_we = 1'b0;
        case (r.st)
            ST_IDLE: begin
                // EEPROM write in progress blocks arming
                if (link.ctrl_write && link.ctrl_wdata[spm_pkg::BIT_ENABLE]
                        && !link.eeprom_write_pending) begin
                    next_r.ctrl = {r.busy, 1'b0, link.ctrl_wdata[5:0]};
                    next_r.st = ST_ARMED;
                    next_r.arm_cnt = 3'h0;
                end
            end
            ST_ARMED: begin
                if (link.store_strobe) begin
                    if (r.ctrl[spm_pkg::BIT_REENABLE]) begin
                        if (!r.block) begin
                            next_r.busy = 1'b0;
                        end
                        next_r.st = ST_IDLE;
                        next_r.ctrl[spm_pkg::BIT_ENABLE] = 1'b0;
                    end else if (r.ctrl[spm_pkg::BIT_ERASE] ||
                                 r.ctrl[spm_pkg::BIT_WRITE] ||
                                 r.ctrl[spm_pkg::BIT_LOCK]) begin
                        next_r.st = ST_PROG;
                        next_r.timer = TW'(PROG_CYCLES);
                        next_r.target_page = page_index;
                        if (!r.ctrl[spm_pkg::BIT_LOCK]) begin
                            next_r.busy = 1'b1;
                            next_r.block = 1'b1;
                            next_r.halt = in_no_concurrent_read_region;
                        end
                    end else begin
                        buf_we = 1'b1;
                        next_r.st = ST_IDLE;
                        next_r.ctrl[spm_pkg::BIT_ENABLE] = 1'b0;
                    end
                end else if (r.arm_cnt == 3'(spm_pkg::ARM_WINDOW - 1)) begin
                    next_r.st = ST_IDLE;
                    next_r.ctrl[spm_pkg::BIT_ENABLE] = 1'b0;
                end else begin
                    next_r.arm_cnt = r.arm_cnt + 3'h1;
                end
            end
            ST_PROG: begin
                if (r.timer == TW'(1)) begin
                    next_r.st = ST_IDLE;
                    next_r.halt = 1'b0;
                    next_r.block = 1'b0;
                    next_r.done = 1'b1;
                    next_r.ctrl[spm_pkg::BIT_ENABLE] = 1'b0;
                end else begin
                    next_r.timer = r.timer - TW'(1);
                end
            end
            default: next_r.st = ST_IDLE;
        endcase
        next_r.ctrl[spm_pkg::BIT_BUSY] = next_r.busy;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Temporary page buffer, no reset needed for data
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (buf_we) begin
            buffer[word_index[$clog2(WORDS)-1:0]] <= link.word_data;
        end
    end

    assign link.ctrl_rdata      = r.ctrl;
    assign link.cpu_halt        = r.halt;
    assign link.fetch_block_rww = r.block;
    assign op_done              = r.done;
endmodule

//--- spm_pkg.sv
package spm_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 100_000_000;
    localparam int PROG_MIN_US     = 3700;
    localparam int PROG_MAX_US     = 4500;
    localparam int PROG_MIN_CYCLES = (PROG_MIN_US * (CLK_HZ / 1_000_000));
    localparam int PROG_MAX_CYCLES = (PROG_MAX_US * (CLK_HZ / 1_000_000));
    localparam int PROG_CYCLES     = (PROG_MIN_CYCLES + PROG_MAX_CYCLES) / 2;
    localparam int ARM_WINDOW      = 4;
    localparam int RESUME_WAIT     = 2;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int BIT_ENABLE   = 0;
    localparam int BIT_ERASE    = 1;
    localparam int BIT_WRITE    = 2;
    localparam int BIT_LOCK     = 3;
    localparam int BIT_REENABLE = 4;
    localparam int BIT_BUSY     = 6;

    // ------------------------------------------------------------
    // Variant geometry
    // ------------------------------------------------------------
    localparam logic [15:0] BOOT_START_4K [4] =
        '{16'h0C00, 16'h0E00, 16'h0F00, 16'h0F80};
    localparam logic [15:0] BOOT_START_8K [4] =
        '{16'h1C00, 16'h1E00, 16'h1F00, 16'h1F80};
    localparam logic [15:0] BOOT_END_4K   = 16'h0FFF;
    localparam logic [15:0] BOOT_END_8K   = 16'h1FFF;
    localparam logic [15:0] NO_CONCURRENT_READ_REGION_START_4K = 16'h0C00;
    localparam logic [15:0] NO_CONCURRENT_READ_REGION_START_8K = 16'h1C00;
    localparam int PAGES_RWW_4K  = 96;
    localparam int PAGES_RWW_8K  = 112;
    localparam int PAGE_LSB_4K   = 6;
    localparam int PAGE_LSB_8K   = 7;
    localparam int PAGE_MSB_4K   = 12;
    localparam int PAGE_MSB_8K   = 13;

    // ------------------------------------------------------------
    // Operation codes (unused; the link carries control bits)
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE, OP_FILL, OP_ERASE, OP_WRITE, OP_LOCK, OP_REENABLE
    } op_type;

    // ------------------------------------------------------------
    // Host register map
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CMD     = 4'h0;
    localparam logic [3:0] REG_POINTER = 4'h1;
    localparam logic [3:0] REG_DATA    = 4'h2;
    localparam logic [3:0] REG_STATUS  = 4'h3;
    localparam logic [3:0] REG_IRQ_ST  = 4'h4;
    localparam logic [3:0] REG_IRQ_CLR = 4'h5;
    localparam logic [3:0] REG_IRQ_EN  = 4'h6;

endpackage

//--- spm_link_if.sv
interface spm_link_if;
    logic [7:0]  ctrl_wdata;
    logic        ctrl_write;
    logic [7:0]  ctrl_rdata;
    logic        store_strobe;
    logic [15:0] pointer;
    logic [15:0] word_data;
    logic        eeprom_write_pending;
    logic [1:0]  boot_size_sel;
    logic        cpu_halt;
    logic        fetch_block_rww;

    modport device (
        input  ctrl_wdata, ctrl_write, store_strobe, pointer, word_data,
               eeprom_write_pending, boot_size_sel,
        output ctrl_rdata, cpu_halt, fetch_block_rww
    );
    modport host (
        output ctrl_wdata, ctrl_write, store_strobe, pointer, word_data,
        input  ctrl_rdata, cpu_halt, fetch_block_rww, eeprom_write_pending
    );
endinterface

//--- spm_host.sv
module spm_host (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Link
    spm_link_if.host         link,
    // Software port
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [15:0]      rdata,
    output logic             irq
);
    typedef enum logic [1:0] {H_IDLE, H_WAIT_EE, H_STORE} hstate_type;

    typedef struct packed {
        hstate_type  st;
        logic [7:0]  cmd;
        logic [15:0] pointer;
        logic [15:0] data;
        logic [1:0]  irq_st;
        logic [1:0]  irq_en;
        logic [15:0] rdata;
        logic        cw;
        logic [7:0]  cwd;
        logic        strobe;
        logic        prev_en;
    } host_type;

    host_type r;
    host_type next_r;
    logic     en_now;

    always_comb begin
        next_r = r;
        next_r.cw = 1'b0;
        next_r.strobe = 1'b0;
        next_r.rdata = 16'h0000;
        en_now = link.ctrl_rdata[spm_pkg::BIT_ENABLE];
        // Event: enable fell (done) sets irq_st[0]
        if (r.prev_en && !en_now) next_r.irq_st[0] = 1'b1;
        if (wr && addr == spm_pkg::REG_IRQ_CLR) begin
            next_r.irq_st = next_r.irq_st & ~wdata[1:0];
            if (r.prev_en && !en_now) next_r.irq_st[0] = 1'b1;
        end
        if (wr && addr == spm_pkg::REG_IRQ_EN) next_r.irq_en = wdata[1:0];
        if (wr && addr == spm_pkg::REG_POINTER) begin
            next_r.pointer = {wdata[15:1], 1'b0};
        end
        if (wr && addr == spm_pkg::REG_DATA) next_r.data = wdata;
        next_r.prev_en = en_now;
        case (r.st)
            H_IDLE: begin
                if (wr && addr == spm_pkg::REG_CMD && !en_now) begin
                    next_r.cmd = wdata[7:0] | 8'h01;
                    if (wdata[spm_pkg::BIT_WRITE]) begin
                        next_r.pointer[5:1] = 5'h00;
                    end
                    next_r.st = H_WAIT_EE;
                end
            end
            H_WAIT_EE: begin
                if (!link.eeprom_write_pending) begin
                    next_r.cw = 1'b1;
                    next_r.cwd = r.cmd;
                    next_r.st = H_STORE;
                end
            end
            H_STORE: begin
                next_r.strobe = 1'b1;
                next_r.st = H_IDLE;
            end
            default: next_r.st = H_IDLE;
        endcase
        if (rd) begin
            case (addr)
                spm_pkg::REG_STATUS: next_r.rdata =
                    {8'h00, link.ctrl_rdata[7:1], en_now || r.st != H_IDLE};
                spm_pkg::REG_POINTER: next_r.rdata = r.pointer;
                spm_pkg::REG_IRQ_ST: next_r.rdata = {14'h0000, r.irq_st};
                spm_pkg::REG_IRQ_EN: next_r.rdata = {14'h0000, r.irq_en};
                default: next_r.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Pointer advance by 2 per fill is left to software
    assign link.ctrl_write   = r.cw;
    assign link.ctrl_wdata   = r.cwd;
    assign link.store_strobe = r.strobe;
    assign link.pointer      = r.pointer;
    assign link.word_data    = r.data;
    assign rdata             = r.rdata;
    assign irq               = |(r.irq_st & r.irq_en);
endmodule

//--- spm_chk.sv
module spm_chk #(
    parameter int PROG_CYCLES = 20
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Link
    input wire logic [7:0]  ctrl_wdata,
    input wire logic        ctrl_write,
    input wire logic [7:0]  ctrl_rdata,
    input wire logic        store_strobe,
    input wire logic [15:0] pointer,
    input wire logic        eeprom_write_pending,
    input wire logic        cpu_halt,
    input wire logic        fetch_block_rww
);
    // ------------------------------------------------------------
    // Command tracking
    // ------------------------------------------------------------
    logic        timed;
    logic        reen;
    logic [31:0] run;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            timed <= 1'b0;
            reen  <= 1'b0;
            run   <= 32'h0;
        end else begin
            if (ctrl_write && !ctrl_rdata[0]) begin
                timed <= |ctrl_wdata[3:1];
                reen  <= ctrl_wdata[4];
            end
            run <= ctrl_rdata[0] ? run + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    host_ee_wait_a: assert property (ctrl_write |-> !eeprom_write_pending)
        else $error("command written during eeprom write");
    host_strobe_a: assert property (ctrl_write |=> store_strobe)
        else $error("store strobe did not follow command");
    ptr_bit0_a: assert property (store_strobe |-> !pointer[0])
        else $error("pointer bit 0 set on store");
    timed_len_a: assert property ($fell(ctrl_rdata[0]) && timed
        |-> run >= PROG_CYCLES && run <= PROG_CYCLES + 4)
        else $error("timed operation length wrong");
    hold_bound_a: assert property (run <= PROG_CYCLES + 6)
        else $error("enable held too long");
    arm_take_a: assert property (ctrl_write && ctrl_wdata[0]
        && !ctrl_rdata[0] && !eeprom_write_pending |-> ##[1:3] ctrl_rdata[0])
        else $error("command not taken");
    discard_a: assert property ((ctrl_write && ctrl_wdata[0] && !ctrl_rdata[0])
        ##1 (!store_strobe)[*5] |-> ##[0:2] !ctrl_rdata[0])
        else $error("unused command not discarded");
    block_busy_a: assert property (fetch_block_rww && $past(fetch_block_rww)
        |-> ctrl_rdata[6])
        else $error("region blocked without busy flag");
    busy_clear_a: assert property ($fell(ctrl_rdata[6]) |-> reen)
        else $error("busy flag cleared without re-enable");
    halt_op_a: assert property (cpu_halt
        |-> ctrl_rdata[0] || $past(ctrl_rdata[0]))
        else $error("core halted outside operation");
    cover property (ctrl_write && ctrl_wdata[1]);
    cover property ($rose(cpu_halt));
    cover property ($fell(ctrl_rdata[6]));
endmodule

//--- flash_self_program_sequencer_tb.sv
module flash_self_program_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Short count keeps the run brief
    localparam int PC = 20;
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, irq;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0, rdata, bs, be, bs8, be8, v, wdata_rb;
    logic [6:0]  pg, pg8;
    logic [5:0]  wd, wd8;
    int          mismatches = 0, checks_done = 0, n;
    spm_link_if link();
    spm_link_if l8();
    always #5 clk = ~clk;
    spm_host u_spm_host(.clk(clk), .rstn(rstn), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    spm_device #(.PROG_CYCLES(PC)) u_spm_device(.clk(clk), .rstn(rstn),
        .link(link), .boot_start(bs), .boot_end(be), .page_index(pg),
        .word_index(wd), .op_done());
    spm_device #(.BIG_VARIANT(1'b1), .PROG_CYCLES(PC)) u_spm_device_8k(
        .clk(clk), .rstn(rstn), .link(l8), .boot_start(bs8),
        .boot_end(be8), .page_index(pg8), .word_index(wd8), .op_done());
    spm_chk #(.PROG_CYCLES(PC)) u_spm_chk(.clk(clk), .rstn(rstn),
        .ctrl_wdata(link.ctrl_wdata), .ctrl_write(link.ctrl_write),
        .ctrl_rdata(link.ctrl_rdata), .store_strobe(link.store_strobe),
        .pointer(link.pointer), .cpu_halt(link.cpu_halt),
        .eeprom_write_pending(link.eeprom_write_pending),
        .fetch_block_rww(link.fetch_block_rww));
    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic wait_en(input logic lvl);
        n = 0;
        while (link.ctrl_rdata[0] !== lvl) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 4 * PC) begin
                mismatches++;
                complete_run();
            end
        end
    endtask
    // Flags f: block, halt, busy
    task automatic op(input logic [15:0] p, input logic [7:0] c,
                      input logic [2:0] f);
        wreg(spm_pkg::REG_POINTER, p);
        wreg(spm_pkg::REG_CMD, {8'h00, c});
        wait_en(1'b1);
        repeat (3) @(posedge clk);
        #1;
        chk({13'h0, link.fetch_block_rww, link.cpu_halt, link.ctrl_rdata[6]},
            {13'h0, f});
        rreg(spm_pkg::REG_STATUS, v);
        chk(v & 16'h0041, {9'h0, f[0], 6'h01});
        wait_en(1'b0);
        chk({15'h0, n + 5 >= PC && n + 5 <= PC + 4}, 16'h1);
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0, link.ctrl_rdata[6]}, {15'h0, f[0]});
    endtask
    initial begin
        link.eeprom_write_pending = 1'b0;
        link.boot_size_sel = 2'h0;
        l8.ctrl_write = 1'b0;
        l8.ctrl_wdata = 8'h00;
        l8.store_strobe = 1'b0;
        l8.pointer = 16'h0;
        l8.word_data = 16'h0;
        l8.eeprom_write_pending = 1'b0;
        l8.boot_size_sel = 2'h0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            link.boot_size_sel <= 2'(i);
            l8.boot_size_sel <= 2'(i);
            @(posedge clk);
            #1;
            chk(bs, 16'h1000 - (16'h0080 << (3 - i)));
            chk(bs8, 16'h2000 - (16'h0080 << (3 - i)));
            chk(be, 16'h0FFF);
            chk(be8, 16'h1FFF);
        end
        v = 16'hA5C2;
        wreg(spm_pkg::REG_POINTER, 16'hA5C3);
        l8.pointer <= v;
        repeat (2) @(posedge clk);
        #1;
        chk(link.pointer, v);
        rreg(spm_pkg::REG_POINTER, wdata_rb);
        chk(wdata_rb, v);
        chk({9'h0, pg}, {9'h0, v[12:6]});
        chk({10'h0, wd}, {11'h0, v[5:1]});
        chk({9'h0, pg8}, {9'h0, v[13:7]});
        chk({10'h0, wd8}, {10'h0, v[6:1]});
        @(posedge clk);
        l8.ctrl_wdata <= 8'h01;
        l8.ctrl_write <= 1'b1;
        @(posedge clk);
        l8.ctrl_write <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk({15'h0, l8.ctrl_rdata[0]}, 16'h0);
        wreg(spm_pkg::REG_IRQ_EN, 16'h0001);
        op(16'h0000, 8'h03, 3'b101);
        chk({15'h0, irq}, 16'h1);
        wreg(spm_pkg::REG_IRQ_CLR, 16'h0001);
        @(posedge clk);
        #1;
        chk({15'h0, irq}, 16'h0);
        wreg(spm_pkg::REG_CMD, 16'h0011);
        repeat (4) @(posedge clk);
        #1;
        chk({14'h0, link.ctrl_rdata[6], link.ctrl_rdata[0]}, 16'h0);
        wreg(spm_pkg::REG_DATA, 16'h1234);
        wreg(spm_pkg::REG_CMD, 16'h0001);
        repeat (4) @(posedge clk);
        #1;
        chk({14'h0, link.ctrl_rdata[6], link.ctrl_rdata[0]}, 16'h0);
        op(16'h1800, 8'h05, 3'b111);
        wreg(spm_pkg::REG_CMD, 16'h0011);
        wreg(spm_pkg::REG_IRQ_EN, 16'h0000);
        wreg(spm_pkg::REG_IRQ_CLR, 16'h0001);
        @(posedge clk);
        link.eeprom_write_pending <= 1'b1;
        op(16'h0001, 8'h09, 3'b000);
        chk({15'h0, irq}, 16'h0);
        wreg(spm_pkg::REG_IRQ_EN, 16'h0001);
        @(posedge clk);
        #1;
        chk({15'h0, irq}, 16'h1);
        complete_run();
    end
    // Releases the eeprom hold while the lock command waits
    initial begin
        for (int k = 0; k < 5000 && link.eeprom_write_pending !== 1'b1; k++)
            @(posedge clk);
        repeat (12) @(posedge clk);
        #1;
        chk({15'h0, link.ctrl_rdata[0]}, 16'h0);
        @(posedge clk);
        link.eeprom_write_pending <= 1'b0;
    end
endmodule
